/* File: rtl/scsi_front_pkg.sv */
package scsi_front_pkg;
  // register map, read and write sides share one index
  localparam logic [3:0] ADR_COUNT_LO = 4'h0;
  localparam logic [3:0] ADR_COUNT_HI = 4'h1;
  localparam logic [3:0] ADR_BUFFER = 4'h2;
  localparam logic [3:0] ADR_COMMAND = 4'h3;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_CAUSE = 4'h5;
  localparam logic [3:0] ADR_STEP = 4'h6;
  localparam logic [3:0] ADR_FILL = 4'h7;
  localparam logic [3:0] ADR_OPTIONS = 4'h8;
  localparam logic [3:0] ADR_CLKDIV = 4'h9;
  localparam logic [3:0] ADR_TEST = 4'hA;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  // command byte fields
  localparam int CMD_DMA_BIT = 7;
  localparam logic [2:0] GRP_MISC = 3'h0;
  localparam logic [2:0] GRP_INIT = 3'h1;
  localparam logic [2:0] GRP_TARGET = 3'h2;
  localparam logic [2:0] GRP_DISC = 3'h4;
  localparam logic [6:0] CMD_NOP = 7'h00;
  localparam logic [6:0] CMD_FLUSH = 7'h01;
  localparam logic [6:0] CMD_CHIP_RESET = 7'h02;
  localparam logic [6:0] CMD_BUS_RESET = 7'h03;
  localparam logic [6:0] CMD_ENABLE_SEL = 7'h44;
  localparam logic [6:0] CMD_PLAIN_DISC = 7'h27;
  localparam logic [6:0] CMD_SET_ATTN = 7'h1A;
  // status, cause and option bit positions
  localparam int STS_GROSS = 6;
  localparam int STS_COUNT_ZERO = 4;
  localparam int CAUSE_BUS_RESET = 7;
  localparam int CAUSE_ILLEGAL = 6;
  localparam int CAUSE_DONE = 3;
  localparam int OPT_NO_RESET_INT = 6;
  // reset values and the maximum count
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [4:0] PERIOD_RESET = 5'h05;
  localparam logic [15:0] LOAD_RESET = 16'h0000;
  localparam logic [16:0] COUNT_MAX = 17'h10000;
  // buffer geometry
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 16;
  // bus reset pulse length
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_RESET_TIME_NS = 25000;
  localparam int BUS_RESET_CYCLES = BUS_RESET_TIME_NS / CLK_PERIOD_NS;
endpackage : scsi_front_pkg

/* File: rtl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] lvl_reg, lvl_next;
  logic push, pop;

  assign in_ready = (lvl_reg != (AW+1)'(DEPTH));
  assign out_valid = (lvl_reg != '0);
  assign out_data = mem_reg[rp_reg];
  assign level = lvl_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_next = wp_reg + AW'(push);
    rp_next = rp_reg + AW'(pop);
    lvl_next = lvl_reg + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wp_next = '0;
      rp_next = '0;
      lvl_next = '0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wp_reg <= '0;
      rp_reg <= '0;
      lvl_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      lvl_reg <= lvl_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule : byte_fifo

/* File: rtl/scsi_cmd_front.sv */
`timescale 1ns/1ps
module scsi_cmd_front (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [3:0] A,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic DMA_GRANT_N,
  input wire logic [7:0] DB_IN,
  output logic [7:0] DB_OUT,
  output logic DB_OE,
  output logic DMA_REQUEST_OUT,
  output logic INT_OUT,
  output logic INT_OE,
  output logic BUS_RESET_DRIVE_N,
  input wire logic BUS_RESET_SENSE_N,
  input wire logic [2:0] SEQ_MODE,
  input wire logic SEQ_RECEIVING,
  input wire logic SEQ_SYNC_INIT,
  input wire logic SEQ_DONE,
  input wire logic SEQ_CLEAR,
  input wire logic [7:0] SEQ_CAUSE_SET,
  input wire logic SEQ_STEP_LOAD,
  input wire logic [2:0] SEQ_STEP,
  input wire logic [2:0] SEQ_PHASE,
  input wire logic SEQ_LEN_LOAD,
  input wire logic [15:0] SEQ_LEN,
  output logic CMD_START,
  output logic [7:0] CMD_CODE,
  output logic CMD_BUSY,
  output logic XFER_DONE,
  input wire logic SCSI_RX_VALID,
  input wire logic [7:0] SCSI_RX_DATA,
  output logic SCSI_RX_READY,
  output logic SCSI_TX_VALID,
  output logic [7:0] SCSI_TX_DATA,
  input wire logic SCSI_TX_READY,
  output logic [7:0] OPTIONS,
  output logic [2:0] TARGET_ID,
  output logic [7:0] SEL_TIMEOUT,
  output logic [4:0] SYNC_PERIOD,
  output logic [3:0] SYNC_OFFSET,
  output logic [7:0] CLK_DIVIDE,
  output logic [7:0] TEST_MODE
);
  // command byte decode, used for legality and interrupt reporting
  function automatic logic cmd_legal(input logic [6:0] c, input logic [2:0] mode);
    logic ok;
    ok = 1'b0;
    if (c[6:4] == scsi_front_pkg::GRP_MISC) begin
      ok = (c[3:2] == 2'b00);
    end else if (c[6:4] == scsi_front_pkg::GRP_DISC) begin
      ok = (c[3:0] <= 4'h5);
    end else if (c[6:4] == scsi_front_pkg::GRP_TARGET) begin
      ok = (c[3:0] <= 4'hB) && (c[3:0] != 4'h6);
    end else if (c[6:4] == scsi_front_pkg::GRP_INIT) begin
      ok = (c[3:0] <= 4'h2) || (c[3:0] == 4'h8) || (c[3:0] == 4'hA);
    end
    if (c[6:4] != scsi_front_pkg::GRP_MISC && c[6:4] != mode) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : cmd_legal

  function automatic logic cmd_reports(input logic [6:0] c);
    return c[6:4] != scsi_front_pkg::GRP_MISC && c != scsi_front_pkg::CMD_ENABLE_SEL
        && c != scsi_front_pkg::CMD_PLAIN_DISC && c != scsi_front_pkg::CMD_SET_ATTN;
  endfunction : cmd_reports

  // two-stage synchronisers for every pin input
  logic [16:0] s1_reg, s2_reg;
  logic [2:0] prev_reg;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_reg <= 17'h1FFFF;
      s2_reg <= 17'h1FFFF;
      prev_reg <= 3'h7;
    end else begin
      s1_reg <= {BUS_RESET_SENSE_N, CS_N, DB_IN, A, DMA_GRANT_N, WR_N, RD_N};
      s2_reg <= s1_reg;
      prev_reg <= {s2_reg[16], s2_reg[1:0]};
    end
  end
  logic rd_n_s, wr_n_s, dma_grant_n_n_s, cs_n_s, rd_fall, wr_fall, sense_fall;
  logic [3:0] adr_s;
  logic [7:0] din_s;
  assign rd_n_s = s2_reg[0];
  assign wr_n_s = s2_reg[1];
  assign dma_grant_n_n_s = s2_reg[2];
  assign adr_s = s2_reg[6:3];
  assign din_s = s2_reg[14:7];
  assign cs_n_s = s2_reg[15];
  assign rd_fall = prev_reg[0] && !rd_n_s;
  assign wr_fall = prev_reg[1] && !wr_n_s;
  assign sense_fall = prev_reg[2] && !s2_reg[16];

  // host and dma strobes; chip select and grant are never both low
  logic cpu_rd, cpu_wr, dma_rd, dma_wr;
  assign cpu_rd = rd_fall && !cs_n_s && dma_grant_n_n_s;
  assign cpu_wr = wr_fall && !cs_n_s && dma_grant_n_n_s;
  assign dma_rd = rd_fall && !dma_grant_n_n_s && cs_n_s;
  assign dma_wr = wr_fall && !dma_grant_n_n_s && cs_n_s;

  // state
  logic [15:0] load_reg, load_next;
  logic [16:0] cnt_reg, cnt_next;
  logic [7:0] opt_reg, opt_next, tmo_reg, tmo_next, ccf_reg, ccf_next, tst_reg, tst_next;
  logic [2:0] id_reg, id_next, step_reg, step_next;
  logic [4:0] per_reg, per_next;
  logic [3:0] ofs_reg, ofs_next;
  logic [7:0] top_reg, top_next, bot_reg, bot_next, cause_reg, cause_next;
  logic top_v_reg, top_v_next, busy_reg, busy_next, got_reg, got_next;
  logic gross_reg, gross_next, tcz_reg, tcz_next, srst_reg, srst_next;
  logic start_reg, start_next, brst_n_reg, brst_n_next;
  logic [11:0] brst_cnt_reg, brst_cnt_next;
  logic [7:0] dout_reg, dout_next;

  // buffer and its arbitration: bus strobes take priority over the scsi side
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
  logic [7:0] f_in_data, f_out_data;
  logic [4:0] f_level;
  logic bus_fwr, bus_frd, dma_on, rx_ok, tx_ok, rx_take, tx_take, int_act;
  logic do_move, legal, clr_q, imm_cmd, dec_evt, int_rd;
  assign bus_fwr = (cpu_wr && adr_s == scsi_front_pkg::ADR_BUFFER) || dma_wr;
  assign bus_frd = (cpu_rd && adr_s == scsi_front_pkg::ADR_BUFFER) || dma_rd;
  assign dma_on = busy_reg && bot_reg[scsi_front_pkg::CMD_DMA_BIT];
  assign rx_ok = busy_reg && SEQ_RECEIVING
      && (dma_on ? (SEQ_SYNC_INIT || cnt_reg != '0) : !got_reg);
  assign tx_ok = busy_reg && !SEQ_RECEIVING;
  assign SCSI_RX_READY = rx_ok && f_in_ready && !bus_fwr;
  assign rx_take = SCSI_RX_VALID && SCSI_RX_READY;
  assign SCSI_TX_VALID = tx_ok && f_out_valid && !bus_frd;
  assign SCSI_TX_DATA = f_out_data;
  assign tx_take = SCSI_TX_VALID && SCSI_TX_READY;
  assign f_in_valid = bus_fwr || rx_take;
  assign f_in_data = bus_fwr ? din_s : SCSI_RX_DATA;
  assign f_out_ready = bus_frd || tx_take;
  assign imm_cmd = cpu_wr && adr_s == scsi_front_pkg::ADR_COMMAND
      && (din_s[6:0] == scsi_front_pkg::CMD_CHIP_RESET
      || din_s[6:0] == scsi_front_pkg::CMD_BUS_RESET);
  // a command write in the same cycle keeps the top entry in place
  assign do_move = top_v_reg && !busy_reg && !int_act && !srst_reg
      && !(cpu_wr && adr_s == scsi_front_pkg::ADR_COMMAND);
  assign legal = cmd_legal(top_reg[6:0], SEQ_MODE);
  assign f_flush = srst_reg
      || (do_move && legal && top_reg[6:0] == scsi_front_pkg::CMD_FLUSH);

  byte_fifo #(.WIDTH(scsi_front_pkg::BUF_WIDTH), .DEPTH(scsi_front_pkg::BUF_DEPTH)) u_buf (
    .CLK(CLK), .RSTN(RSTN), .flush(f_flush),
    .in_valid(f_in_valid), .in_ready(f_in_ready), .in_data(f_in_data),
    .out_valid(f_out_valid), .out_ready(f_out_ready), .out_data(f_out_data),
    .level(f_level)
  );

  // counter: decrement source depends on direction and mode
  always_comb begin
    if (!dma_on) begin
      dec_evt = 1'b0;
    end else if (!SEQ_RECEIVING) begin
      dec_evt = dma_wr && f_in_ready;
    end else if (SEQ_SYNC_INIT) begin
      dec_evt = dma_rd && f_out_valid;
    end else begin
      dec_evt = rx_take;
    end
  end

  assign int_act = (cause_reg != '0);
  assign int_rd = cpu_rd && adr_s == scsi_front_pkg::ADR_CAUSE && int_act;
  assign clr_q = SEQ_CLEAR || (do_move && !legal)
      || (sense_fall && !opt_reg[scsi_front_pkg::OPT_NO_RESET_INT]);

  // host-written configuration and count load
  always_comb begin
    load_next = load_reg;
    opt_next = opt_reg;
    id_next = id_reg;
    tmo_next = tmo_reg;
    per_next = per_reg;
    ofs_next = ofs_reg;
    ccf_next = ccf_reg;
    tst_next = tst_reg;
    if (srst_reg) begin
      load_next = scsi_front_pkg::LOAD_RESET;
      opt_next = scsi_front_pkg::OPTIONS_RESET;
      per_next = scsi_front_pkg::PERIOD_RESET;
    end else if (cpu_wr) begin
      // writes to read-only names land in the write-side register
      if (adr_s == scsi_front_pkg::ADR_COUNT_LO) begin
        load_next[7:0] = din_s;
      end else if (adr_s == scsi_front_pkg::ADR_COUNT_HI) begin
        load_next[15:8] = din_s;
      end else if (adr_s == scsi_front_pkg::ADR_STATUS) begin
        id_next = din_s[2:0];
      end else if (adr_s == scsi_front_pkg::ADR_CAUSE) begin
        tmo_next = din_s;
      end else if (adr_s == scsi_front_pkg::ADR_STEP) begin
        per_next = din_s[4:0];
      end else if (adr_s == scsi_front_pkg::ADR_FILL) begin
        ofs_next = din_s[3:0];
      end else if (adr_s == scsi_front_pkg::ADR_OPTIONS) begin
        opt_next = din_s;
      end else if (adr_s == scsi_front_pkg::ADR_CLKDIV) begin
        ccf_next = din_s;
      end else if (adr_s == scsi_front_pkg::ADR_TEST) begin
        tst_next = din_s;
      end
    end
  end

  // command queue, counter, status and cause
  always_comb begin
    top_next = top_reg;
    top_v_next = top_v_reg;
    bot_next = bot_reg;
    busy_next = busy_reg;
    got_next = got_reg || rx_take;
    start_next = 1'b0;
    cnt_next = cnt_reg;
    tcz_next = tcz_reg;
    cause_next = cause_reg;
    step_next = step_reg;
    gross_next = gross_reg;
    srst_next = 1'b0;
    if (int_rd) begin
      cause_next = '0;
      step_next = '0;
      gross_next = 1'b0;
    end
    if (SEQ_STEP_LOAD) begin
      step_next = SEQ_STEP;
    end
    cause_next = cause_next | SEQ_CAUSE_SET;
    if (SEQ_DONE && busy_reg) begin
      busy_next = 1'b0;
      if (cmd_reports(bot_reg[6:0])) begin
        cause_next[scsi_front_pkg::CAUSE_DONE] = 1'b1;
      end
    end
    if (cpu_wr && adr_s == scsi_front_pkg::ADR_COMMAND && !imm_cmd) begin
      if (top_v_reg) begin
        gross_next = 1'b1;
      end
      top_next = din_s;
      top_v_next = 1'b1;
    end else if (do_move) begin
      top_v_next = 1'b0;
      bot_next = top_reg;
      if (!legal) begin
        cause_next[scsi_front_pkg::CAUSE_ILLEGAL] = 1'b1;
      end else if (top_reg[6:4] != scsi_front_pkg::GRP_MISC) begin
        busy_next = 1'b1;
        start_next = 1'b1;
        got_next = 1'b0;
        if (top_reg[scsi_front_pkg::CMD_DMA_BIT]) begin
          cnt_next = (load_reg == '0) ? scsi_front_pkg::COUNT_MAX : {1'b0, load_reg};
          tcz_next = 1'b0;
        end
      end
    end
    if (bus_fwr && !f_in_ready) begin
      gross_next = 1'b1;
    end
    if (SEQ_LEN_LOAD) begin
      cnt_next = {1'b0, SEQ_LEN};
      tcz_next = 1'b0;
    end else if (dec_evt && cnt_reg != '0) begin
      cnt_next = cnt_reg - 17'h00001;
      tcz_next = (cnt_reg == 17'h00001);
    end
    if (sense_fall && !opt_reg[scsi_front_pkg::OPT_NO_RESET_INT]) begin
      cause_next[scsi_front_pkg::CAUSE_BUS_RESET] = 1'b1;
    end
    if (clr_q) begin
      top_v_next = 1'b0;
      busy_next = 1'b0;
      bot_next = '0;
    end
    if (cpu_wr && adr_s == scsi_front_pkg::ADR_COMMAND
        && din_s[6:0] == scsi_front_pkg::CMD_CHIP_RESET) begin
      srst_next = 1'b1;
    end
    if (srst_reg) begin
      top_next = '0;
      top_v_next = 1'b0;
      bot_next = '0;
      busy_next = 1'b0;
      got_next = 1'b0;
      cnt_next = '0;
      tcz_next = 1'b0;
      cause_next = '0;
      step_next = '0;
      gross_next = 1'b0;
    end
  end

  // bus reset drive and read data
  always_comb begin
    brst_cnt_next = brst_cnt_reg;
    if (cpu_wr && adr_s == scsi_front_pkg::ADR_COMMAND
        && din_s[6:0] == scsi_front_pkg::CMD_BUS_RESET) begin
      brst_cnt_next = 12'(scsi_front_pkg::BUS_RESET_CYCLES);
    end else if (brst_cnt_reg != '0) begin
      brst_cnt_next = brst_cnt_reg - 12'h001;
    end
    brst_n_next = (brst_cnt_next == '0);
    dout_next = dout_reg;
    if (rd_fall) begin
      if (!dma_grant_n_n_s || adr_s == scsi_front_pkg::ADR_BUFFER) begin
        dout_next = f_out_data;
      end else if (adr_s == scsi_front_pkg::ADR_COUNT_LO) begin
        dout_next = cnt_reg[7:0];
      end else if (adr_s == scsi_front_pkg::ADR_COUNT_HI) begin
        dout_next = cnt_reg[15:8];
      end else if (adr_s == scsi_front_pkg::ADR_COMMAND) begin
        dout_next = bot_reg;
      end else if (adr_s == scsi_front_pkg::ADR_STATUS) begin
        dout_next = {1'b0, gross_reg, 1'b0, tcz_reg, 1'b0, SEQ_PHASE};
      end else if (adr_s == scsi_front_pkg::ADR_CAUSE) begin
        dout_next = cause_reg;
      end else if (adr_s == scsi_front_pkg::ADR_STEP) begin
        dout_next = {5'h00, step_reg};
      end else if (adr_s == scsi_front_pkg::ADR_FILL) begin
        dout_next = {3'h0, f_level};
      end else if (adr_s == scsi_front_pkg::ADR_OPTIONS) begin
        dout_next = opt_reg;
      end else begin
        dout_next = scsi_front_pkg::RESERVED_READ;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      load_reg <= scsi_front_pkg::LOAD_RESET;
      opt_reg <= scsi_front_pkg::OPTIONS_RESET;
      id_reg <= '0;
      tmo_reg <= '0;
      per_reg <= scsi_front_pkg::PERIOD_RESET;
      ofs_reg <= '0;
      ccf_reg <= '0;
      tst_reg <= '0;
      top_reg <= '0;
      top_v_reg <= 1'b0;
      bot_reg <= '0;
      busy_reg <= 1'b0;
      got_reg <= 1'b0;
      start_reg <= 1'b0;
      cnt_reg <= '0;
      tcz_reg <= 1'b0;
      cause_reg <= '0;
      step_reg <= '0;
      gross_reg <= 1'b0;
      srst_reg <= 1'b0;
      brst_cnt_reg <= '0;
      brst_n_reg <= 1'b1;
      dout_reg <= '0;
    end else begin
      load_reg <= load_next;
      opt_reg <= opt_next;
      id_reg <= id_next;
      tmo_reg <= tmo_next;
      per_reg <= per_next;
      ofs_reg <= ofs_next;
      ccf_reg <= ccf_next;
      tst_reg <= tst_next;
      top_reg <= top_next;
      top_v_reg <= top_v_next;
      bot_reg <= bot_next;
      busy_reg <= busy_next;
      got_reg <= got_next;
      start_reg <= start_next;
      cnt_reg <= cnt_next;
      tcz_reg <= tcz_next;
      cause_reg <= cause_next;
      step_reg <= step_next;
      gross_reg <= gross_next;
      srst_reg <= srst_next;
      brst_cnt_reg <= brst_cnt_next;
      brst_n_reg <= brst_n_next;
      dout_reg <= dout_next;
    end
  end

  // outputs
  assign DB_OUT = dout_reg;
  assign DB_OE = !rd_n_s && (!cs_n_s || !dma_grant_n_n_s);
  assign DMA_REQUEST_OUT = dma_on && (SEQ_RECEIVING
      ? (f_out_valid && (!SEQ_SYNC_INIT || cnt_reg != '0))
      : (f_in_ready && cnt_reg != '0));
  assign INT_OUT = 1'b0;
  assign INT_OE = int_act;
  assign BUS_RESET_DRIVE_N = brst_n_reg;
  assign CMD_START = start_reg;
  assign CMD_CODE = bot_reg;
  assign CMD_BUSY = busy_reg;
  assign XFER_DONE = busy_reg && !f_out_valid
      && (dma_on ? cnt_reg == '0 : (!SEQ_RECEIVING || got_reg));
  assign OPTIONS = opt_reg;
  assign TARGET_ID = id_reg;
  assign SEL_TIMEOUT = tmo_reg;
  assign SYNC_PERIOD = per_reg;
  assign SYNC_OFFSET = ofs_reg;
  assign CLK_DIVIDE = ccf_reg;
  assign TEST_MODE = tst_reg;

  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_LOAD_COUNT: assert property (do_move && legal && top_reg[7] && top_reg[6:4] != 3'h0
      && load_reg != '0 && !SEQ_LEN_LOAD |=> cnt_reg == {1'b0, $past(load_reg)})
    else $error("counter not loaded from load register");
  AST_ZERO_IS_MAX: assert property (do_move && legal && top_reg[7] && top_reg[6:4] != 3'h0
      && load_reg == '0 && !SEQ_LEN_LOAD && !srst_reg |=> cnt_reg == 17'h10000)
    else $error("zero load did not give maximum count");
  AST_LOAD_KEPT: assert property (CMD_START && !$past(cpu_wr) |-> load_reg == $past(load_reg))
    else $error("load register changed by command start");
  AST_GROSS_CMD: assert property (cpu_wr && adr_s == 4'h3 && !imm_cmd && top_v_reg
      && !srst_reg |=> gross_reg)
    else $error("command overwrite missed gross error");
  AST_GROSS_BUF: assert property (bus_fwr && !f_in_ready && !srst_reg |=> gross_reg)
    else $error("buffer overwrite missed gross error");
  AST_INT_CLEAR: assert property (int_rd && SEQ_CAUSE_SET == '0 && !SEQ_DONE && !do_move
      && !sense_fall |=> !INT_OE
      && step_reg == ($past(SEQ_STEP_LOAD) ? $past(SEQ_STEP) : 3'h0))
    else $error("interrupt read did not clear");
  AST_GROSS_NO_INT: assert property (!int_act && SEQ_CAUSE_SET == '0 && !SEQ_DONE && !do_move
      && !sense_fall ##1 gross_reg |-> !INT_OE)
    else $error("gross error raised interrupt");
  AST_ILLEGAL: assert property (do_move && !legal && !srst_next |=>
      cause_reg[6] && !busy_reg && bot_reg == 8'h00)
    else $error("illegal command not reported");
  AST_ONE_BYTE: assert property (rx_take && !dma_on ##1 busy_reg && !CMD_START |-> !SCSI_RX_READY)
    else $error("non-dma receive took a second byte");
  AST_BUS_RESET: assert property (imm_cmd && din_s[0] |=> ##1 !BUS_RESET_DRIVE_N [*2])
    else $error("bus reset not driven at once");
  COV_START: cover property (CMD_START ##[1:20] XFER_DONE);
  COV_STACK: cover property (top_v_reg && busy_reg ##[1:50] CMD_START);
  COV_ILLEGAL: cover property (do_move && !legal);
  COV_FULL: cover property (!f_in_ready);
endmodule : scsi_cmd_front

/* File: sim/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
  input wire logic CLK,
  input wire logic [7:0] DB_OUT,
  output logic [3:0] A,
  output logic CS_N,
  output logic RD_N,
  output logic WR_N,
  output logic DMA_GRANT_N,
  output logic [7:0] DB_IN
);
  initial begin
    A = 4'h0;
    CS_N = 1'b1;
    RD_N = 1'b1;
    WR_N = 1'b1;
    DMA_GRANT_N = 1'b1;
    DB_IN = 8'hFF;
  end
  task automatic acc(input logic w, input logic dm, input logic [3:0] ad, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge CLK);
    A <= ad;
    DB_IN <= d;
    CS_N <= dm;
    DMA_GRANT_N <= !dm;
    repeat (3) @(posedge CLK);
    WR_N <= !w;
    RD_N <= w;
    repeat (5) @(posedge CLK);
    q = DB_OUT;
    WR_N <= 1'b1;
    RD_N <= 1'b1;
    repeat (4) @(posedge CLK);
    CS_N <= 1'b1;
    DMA_GRANT_N <= 1'b1;
    // released bus floats up to its pull-ups
    DB_IN <= 8'hFF;
  endtask : acc
endmodule : host_bus_model

/* File: sim/scsi_cmd_front_tb.sv */
`timescale 1ns/1ps
module scsi_cmd_front_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic done = 1'b0;
  logic len_ld = 1'b0;
  logic [2:0] mode = 3'h2;
  logic [2:0] phase = 3'h0;
  logic [2:0] step = 3'h0;
  logic [7:0] rxd = 8'h00;
  logic [15:0] len = 16'h0000;
  logic rcv = 1'b0;
  logic rxv = 1'b0;
  logic txr = 1'b0;
  logic [7:0] cset = 8'h00;
  logic [3:0] a;
  logic cs_n, rd_n, wr_n, gnt_n, int_oe, dma_request_out, brst_n, busy, txv;
  logic [7:0] db_in, db_out, code, q, opts, txd;
  logic [2:0] tid;
  logic [15:0] ld;
  logic [7:0] d [16];
  logic [7:0] tc [8] = '{8'h20, 8'h21, 8'h22, 8'h25, 8'h28, 8'h29, 8'h2A, 8'h2B};
  int n_mismatch = 0;
  int n_checks = 0;
  int k;
  int n_rx = 0;
  initial forever #5 clk = ~clk;
  host_bus_model i_host (.CLK(clk), .DB_OUT(db_out), .A(a), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .DMA_GRANT_N(gnt_n), .DB_IN(db_in));
  scsi_cmd_front i_dut (.CLK(clk), .RSTN(rstn), .A(a), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .DMA_GRANT_N(gnt_n), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(),
    .DMA_REQUEST_OUT(dma_request_out), .INT_OUT(), .INT_OE(int_oe), .BUS_RESET_DRIVE_N(brst_n),
    .BUS_RESET_SENSE_N(1'b1), .SEQ_MODE(mode), .SEQ_RECEIVING(rcv), .SEQ_SYNC_INIT(1'b0),
    .SEQ_DONE(done), .SEQ_CLEAR(1'b0), .SEQ_CAUSE_SET(cset), .SEQ_STEP_LOAD(1'b0),
    .SEQ_STEP(step), .SEQ_PHASE(phase), .SEQ_LEN_LOAD(len_ld), .SEQ_LEN(len),
    .CMD_START(), .CMD_CODE(code), .CMD_BUSY(busy), .XFER_DONE(), .SCSI_RX_VALID(rxv),
    .SCSI_RX_DATA(rxd), .SCSI_RX_READY(), .SCSI_TX_VALID(txv), .SCSI_TX_DATA(txd),
    .SCSI_TX_READY(txr), .OPTIONS(opts), .TARGET_ID(tid), .SEL_TIMEOUT(), .SYNC_PERIOD(),
    .SYNC_OFFSET(), .CLK_DIVIDE(), .TEST_MODE());
  // counter value after a dma start, less the one byte already counted when dec is set
  function automatic logic [15:0] exp_cnt(logic [15:0] l, logic dec);
    logic [16:0] c;
    c = (l == 16'h0000) ? 17'h10000 : {1'b0, l};
    return 16'(c - {16'h0000, dec});
  endfunction : exp_cnt
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic rw(logic w, logic [3:0] ad, logic [7:0] dv);
    i_host.acc(w, 1'b0, ad, dv, q);
    #1;
  endtask : rw
  task automatic fin();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rw(1'b0, scsi_front_pkg::ADR_STATUS, 8'h00);
    rw(1'b0, scsi_front_pkg::ADR_CAUSE, 8'h00);
    chk("cause done", 16'h1, q[3]);
  endtask : fin
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    void'($urandom(42114));
    phase <= 3'($urandom);
    step <= 3'($urandom);
    rxd <= 8'($urandom);
    rw(1'b0, 4'h9, 8'h00);
    chk("reserved", scsi_front_pkg::RESERVED_READ, q);
    ld[7:0] = 8'($urandom);
    rw(1'b1, scsi_front_pkg::ADR_OPTIONS, ld[7:0]);
    rw(1'b1, scsi_front_pkg::ADR_STATUS, 8'h05);
    rw(1'b0, scsi_front_pkg::ADR_OPTIONS, 8'h00);
    chk("options", ld[7:0], q);
    chk("options out", ld[7:0], opts);
    chk("target id", 16'h5, tid);
    for (k = 0; k < 16; k++) begin
      d[k] = 8'($urandom);
      rw(1'b1, scsi_front_pkg::ADR_BUFFER, d[k]);
    end
    rw(1'b0, scsi_front_pkg::ADR_FILL, 8'h00);
    chk("fill", 16'h10, q[4:0]);
    rw(1'b1, scsi_front_pkg::ADR_BUFFER, 8'h5A);
    rw(1'b0, scsi_front_pkg::ADR_STATUS, 8'h00);
    chk("gross", 16'h1, q[6]);
    chk("phase", phase, q[2:0]);
    chk("no int", 16'h0, int_oe);
    for (k = 0; k < 16; k++) begin
      rw(1'b0, scsi_front_pkg::ADR_BUFFER, 8'h00);
      chk("buffer", d[k], q);
    end
    rw(1'b1, scsi_front_pkg::ADR_COMMAND, 8'h10);
    chk("illegal int", 16'h1, int_oe);
    rw(1'b0, scsi_front_pkg::ADR_CAUSE, 8'h00);
    chk("illegal", 16'h1, q[6]);
    chk("int clear", 16'h0, int_oe);
    ld = 16'($urandom_range(65535, 1));
    for (k = 0; k < 3; k++) begin
      if (k == 2) ld = 16'h0000;
      if (k != 1) rw(1'b1, scsi_front_pkg::ADR_COUNT_LO, ld[7:0]);
      if (k != 1) rw(1'b1, scsi_front_pkg::ADR_COUNT_HI, ld[15:8]);
      rw(1'b1, scsi_front_pkg::ADR_COMMAND, 8'hA2);
      chk("dma_request_out", 16'h1, dma_request_out);
      // one dma byte makes a zero load show up as FFFF, one below the maximum count
      if (k == 2) i_host.acc(1'b1, 1'b1, 4'h0, 8'h33, q);
      rw(1'b0, scsi_front_pkg::ADR_COUNT_LO, 8'h00);
      chk("count lo", exp_cnt(ld, k == 2) & 16'h00FF, q);
      rw(1'b0, scsi_front_pkg::ADR_COUNT_HI, 8'h00);
      chk("count hi", exp_cnt(ld, k == 2) >> 8, q);
      rw(1'b0, scsi_front_pkg::ADR_STATUS, 8'h00);
      chk("zero flag", 16'h0, q[4]);
      if (k == 2) begin
        chk("tx", 16'h133, {txv, txd});
        @(posedge clk);
        txr <= 1'b1;
        @(posedge clk);
        txr <= 1'b0;
      end
      fin();
    end
    foreach (tc[j]) begin
      rw(1'b1, scsi_front_pkg::ADR_COMMAND, tc[j]);
      chk("code", tc[j], code);
      chk("busy", 16'h1, busy);
      if (tc[j][3]) begin
        @(posedge clk);
        rcv <= 1'b1;
        rxv <= 1'b1;
        repeat (3) @(posedge clk);
        rcv <= 1'b0;
        rxv <= 1'b0;
        n_rx++;
        rw(1'b0, scsi_front_pkg::ADR_FILL, 8'h00);
        chk("one byte", 16'(n_rx), q[4:0]);
      end
      fin();
    end
    rw(1'b1, scsi_front_pkg::ADR_COMMAND, 8'h22);
    rw(1'b1, scsi_front_pkg::ADR_COMMAND, 8'h21);
    rw(1'b1, scsi_front_pkg::ADR_COMMAND, 8'h25);
    rw(1'b0, scsi_front_pkg::ADR_STATUS, 8'h00);
    chk("gross cmd", 16'h1, q[6]);
    rw(1'b0, scsi_front_pkg::ADR_COMMAND, 8'h00);
    chk("bottom", 16'h22, q);
    fin();
    chk("top moved", 16'h25, code);
    @(posedge clk);
    len <= 16'($urandom);
    len_ld <= 1'b1;
    @(posedge clk);
    len_ld <= 1'b0;
    rw(1'b0, scsi_front_pkg::ADR_COUNT_LO, 8'h00);
    ld[7:0] = q;
    rw(1'b0, scsi_front_pkg::ADR_COUNT_HI, 8'h00);
    chk("length", len, {q, ld[7:0]});
    rw(1'b1, scsi_front_pkg::ADR_COMMAND, 8'h03);
    chk("bus reset", 16'h0, brst_n);
    chk("queue kept", 16'h25, code);
    repeat (scsi_front_pkg::BUS_RESET_CYCLES) @(posedge clk);
    chk("bus reset end", 16'h1, brst_n);
    end_of_test();
  end
endmodule : scsi_cmd_front_tb
